// >>> verilog/iors_consts.vh
// constants of the i/o register space decoder
// Contract
// - bit set/clear only reaches i/o 0x00-0x1f
// - skip tests read one bit there
// - some flags clear on written one
// - bit ops change only the addressed bit
// - port-style transfers use i/o 0x00-0x3f
// - data address is i/o address plus 0x20
// - extended 0x60-0xff only by data access
// - stack pointer high keeps bits nine, eight
`ifndef IORS_CONSTS_VH
`define IORS_CONSTS_VH
// operation codes from the cpu datapath
`define IORS_OP_IDLE 4'h0
`define IORS_OP_PORT_RD 4'h1
`define IORS_OP_PORT_WR 4'h2
`define IORS_OP_FETCH 4'h3
`define IORS_OP_WRITE 4'h4
`define IORS_OP_BIT_SET 4'h5
`define IORS_OP_BIT_CLR 4'h6
`define IORS_OP_SKIP_HI 4'h7
`define IORS_OP_SKIP_LO 4'h8
// address ranges
`define IORS_IO_LAST 8'h3f
`define IORS_BIT_LAST 8'h1f
`define IORS_IO_OFS 8'h20
`define IORS_LOW_DATA_LAST 8'h5f
`define IORS_EXT_FIRST 8'h60
`define IORS_RESET_VAL 8'h00
// low register data addresses
`define IORS_PORT_B_PIN_INPUT 8'h23
`define IORS_PORT_B_DIRECTION 8'h24
`define IORS_PORT_B_OUTPUT 8'h25
`define IORS_PORT_C_PIN_INPUT 8'h26
`define IORS_PORT_C_DIRECTION 8'h27
`define IORS_PORT_C_OUTPUT 8'h28
`define IORS_PORT_D_PIN_INPUT 8'h29
`define IORS_PORT_D_DIRECTION 8'h2a
`define IORS_PORT_D_OUTPUT 8'h2b
`define IORS_CLOCK_MGMT_CONTROL 8'h2f
`define IORS_CLOCK_MGMT_FLAGS 8'h30
`define IORS_TIMER2_CONTROL_A 8'h31
`define IORS_TIMER2_CONTROL_B 8'h32
`define IORS_TIMER3_CONTROL_A 8'h34
`define IORS_VOLTAGE_MONITOR_CTL 8'h36
`define IORS_PIN_CHANGE_FLAGS 8'h37
`define IORS_LF_RECEIVER_FLAGS 8'h38
`define IORS_SENSOR_FLAGS 8'h39
`define IORS_TIMER01_FLAGS 8'h3a
`define IORS_TIMER2_FLAGS 8'h3b
`define IORS_TIMER3_FLAGS 8'h3c
`define IORS_EXTERNAL_IRQ_FLAGS 8'h3d
`define IORS_SCRATCH_BYTE_0 8'h3e
`define IORS_EEPROM_CONTROL 8'h3f
`define IORS_EEPROM_DATA 8'h40
`define IORS_EEPROM_ADDR_LOW 8'h41
`define IORS_EEPROM_ADDR_HIGH 8'h42
`define IORS_PIN_CHANGE_IRQ_ENABLE 8'h43
`define IORS_EXTERNAL_IRQ_MASK 8'h44
`define IORS_SENSOR_VOLTAGE_CTL 8'h47
`define IORS_SENSOR_CONTROL 8'h48
`define IORS_SENSOR_CAP_CONFIG 8'h49
`define IORS_SCRATCH_BYTE_1 8'h4a
`define IORS_SCRATCH_BYTE_2 8'h4b
`define IORS_SERIAL_PORT_CONTROL 8'h4c
`define IORS_SERIAL_PORT_FLAGS 8'h4d
`define IORS_SERIAL_PORT_DATA 8'h4e
`define IORS_MODULATOR_DATA 8'h4f
`define IORS_LF_SIGNAL_STRENGTH 8'h50
`define IORS_LF_CLOCK_DIVIDER 8'h52
`define IORS_SLEEP_MODE_CONTROL 8'h53
`define IORS_RESET_CAUSE_FLAGS 8'h54
`define IORS_CORE_CONTROL 8'h55
`define IORS_LF_RX_BUFFER 8'h56
`define IORS_SELF_PROGRAM_CTL 8'h57
`define IORS_TIMER1_CONTROL 8'h58
`define IORS_TIMER0_CONTROL 8'h59
`define IORS_CLOCK_MGMT_IRQ_MASK 8'h5b
`define IORS_CLOCK_PRESCALE 8'h5c
`define IORS_STACK_PTR_LOW 8'h5d
`define IORS_STACK_PTR_HIGH 8'h5e
`define IORS_STATUS_FLAGS 8'h5f
// extended register data addresses
`define IORS_WATCHDOG_CONTROL 8'h60
`define IORS_SENSOR_IRQ_MASK 8'h61
`define IORS_TEMP_SENSOR_CTL 8'h64
// extended register writable bits
`define IORS_WATCHDOG_MASK 8'h1f
`define IORS_SENSOR_IRQ_MASK_BITS 8'h01
`define IORS_TEMP_SENSOR_BITS 8'h01
`endif

// >>> verilog/iors_addr_map.v
// address decode for port-style, bit and data-space accesses
`timescale 1ns/100ps
`default_nettype none
`include "iors_consts.vh"
module iors_addr_map (
  input wire [3:0] op_i,
  input wire [7:0] addr_i,
  output wire low_hit_o,
  output wire [5:0] low_idx_o,
  output wire ext_hit_o
);
  // op groups
  wire is_port = (op_i == `IORS_OP_PORT_RD) || (op_i == `IORS_OP_PORT_WR);
  wire is_data = (op_i == `IORS_OP_FETCH) || (op_i == `IORS_OP_WRITE);
  wire is_bit = (op_i >= `IORS_OP_BIT_SET) && (op_i <= `IORS_OP_SKIP_LO);
  // data address minus offset gives the i/o location
  wire [7:0] data_io = addr_i - `IORS_IO_OFS;
  wire data_low = (addr_i >= `IORS_IO_OFS) &&
                  (addr_i <= `IORS_LOW_DATA_LAST);
  assign low_hit_o = (is_port && addr_i <= `IORS_IO_LAST) ||
                     (is_bit && addr_i <= `IORS_BIT_LAST) ||
                     (is_data && data_low);
  assign low_idx_o = is_data ? data_io[5:0] : addr_i[5:0];
  // extended space only for data-space forms
  assign ext_hit_o = is_data && (addr_i >= `IORS_EXT_FIRST);
endmodule
`default_nettype wire

// >>> verilog/iors_bit_sel.v
// one-hot lane and single bit pick for bit operations
`timescale 1ns/100ps
`default_nettype none
module iors_bit_sel (
  input wire [7:0] byte_i,
  input wire [2:0] bit_i,
  output wire [7:0] onehot_o,
  output wire bit_o
);
  // one lane selected by the bit number
  assign onehot_o = 8'h01 << bit_i;
  // chosen bit of the byte
  assign bit_o = byte_i[bit_i];
endmodule
`default_nettype wire

// >>> verilog/iors_decoder.v
// i/o register space decoder with storage of the low and extended registers
`timescale 1ns/100ps
`default_nettype none
`include "iors_consts.vh"
module iors_decoder (
  input wire core_clk_i,
  input wire rstn_i,
  input wire [3:0] op_i,
  input wire [7:0] addr_i,
  input wire [7:0] wdata_i,
  input wire [2:0] bit_i,
  input wire evt_valid_i,
  input wire [7:0] evt_addr_i,
  input wire [7:0] evt_bits_i,
  input wire [7:0] port_b_pin_input_i,
  input wire [7:0] port_c_pin_input_i,
  input wire [7:0] port_d_pin_input_i,
  input wire [6:0] lf_rssi_i,
  input wire [7:0] lf_rxbuf_i,
  output reg [7:0] rd_data_o,
  output reg rd_valid_o,
  output reg skip_o,
  output reg err_o,
  output wire [7:0] port_b_output_out_o,
  output wire [7:0] port_b_output_dir_o,
  output wire [7:0] port_c_output_out_o,
  output wire [7:0] port_c_output_dir_o,
  output wire [7:0] port_d_output_out_o,
  output wire [7:0] port_d_output_dir_o,
  output wire [9:0] stack_ptr_o
);

  // storage of the 64 low locations, one byte each
  // the index is the i/o-relative address, data address minus 0x20
  reg [7:0] io_mem [0:63];
  // extended registers held here
  reg [7:0] wdt_ctl;
  reg [7:0] sens_irq_msk;
  reg [7:0] temp_ctl;
  // next values of the response flops
  reg [7:0] next_rd_data;
  reg next_skip;
  reg next_err;

  // writable bits of each low location, zero where reserved
  // bits outside this mask and the flag mask are never stored, so they read back zero except at the live input locations
  function [7:0] rw_mask;
    input [7:0] a;
    begin
      case (a)
        `IORS_PORT_B_DIRECTION: rw_mask = 8'hff;
        `IORS_PORT_B_OUTPUT: rw_mask = 8'hff;
        `IORS_PORT_C_DIRECTION: rw_mask = 8'h07;
        `IORS_PORT_C_OUTPUT: rw_mask = 8'h07;
        `IORS_PORT_D_DIRECTION: rw_mask = 8'hff;
        `IORS_PORT_D_OUTPUT: rw_mask = 8'hff;
        `IORS_CLOCK_MGMT_CONTROL: rw_mask = 8'hbd;
        `IORS_TIMER2_CONTROL_A: rw_mask = 8'hef;
        `IORS_TIMER2_CONTROL_B: rw_mask = 8'h01;
        `IORS_TIMER3_CONTROL_A: rw_mask = 8'hc7;
        `IORS_VOLTAGE_MONITOR_CTL: rw_mask = 8'hdf;
        `IORS_SCRATCH_BYTE_0: rw_mask = 8'hff;
        `IORS_EEPROM_CONTROL: rw_mask = 8'h3f;
        `IORS_EEPROM_DATA: rw_mask = 8'hff;
        `IORS_EEPROM_ADDR_LOW: rw_mask = 8'hff;
        `IORS_EEPROM_ADDR_HIGH: rw_mask = 8'h01;
        `IORS_PIN_CHANGE_IRQ_ENABLE: rw_mask = 8'h07;
        `IORS_EXTERNAL_IRQ_MASK: rw_mask = 8'h03;
        `IORS_SENSOR_VOLTAGE_CTL: rw_mask = 8'h1f;
        `IORS_SENSOR_CONTROL: rw_mask = 8'h0f;
        `IORS_SENSOR_CAP_CONFIG: rw_mask = 8'h1f;
        `IORS_SCRATCH_BYTE_1: rw_mask = 8'hff;
        `IORS_SCRATCH_BYTE_2: rw_mask = 8'hff;
        `IORS_SERIAL_PORT_CONTROL: rw_mask = 8'hff;
        `IORS_SERIAL_PORT_FLAGS: rw_mask = 8'h01;
        `IORS_SERIAL_PORT_DATA: rw_mask = 8'hff;
        `IORS_MODULATOR_DATA: rw_mask = 8'hff;
        `IORS_LF_CLOCK_DIVIDER: rw_mask = 8'hc1;
        `IORS_SLEEP_MODE_CONTROL: rw_mask = 8'h0f;
        `IORS_CORE_CONTROL: rw_mask = 8'h13;
        `IORS_SELF_PROGRAM_CTL: rw_mask = 8'hdf;
        `IORS_TIMER1_CONTROL: rw_mask = 8'hbf;
        `IORS_TIMER0_CONTROL: rw_mask = 8'hff;
        `IORS_CLOCK_MGMT_IRQ_MASK: rw_mask = 8'h01;
        `IORS_CLOCK_PRESCALE: rw_mask = 8'hbf;
        `IORS_STACK_PTR_LOW: rw_mask = 8'hff;
        // only bits nine and eight kept in the high byte
        `IORS_STACK_PTR_HIGH: rw_mask = 8'h03;
        `IORS_STATUS_FLAGS: rw_mask = 8'h7f;
        // reserved and read-only locations store nothing
        default: rw_mask = 8'h00;
      endcase
    end
  endfunction

  // flag bits that hardware sets and a written one clears
  // flag bits never take written data; only events raise them
  function [7:0] w1c_mask;
    input [7:0] a;
    begin
      case (a)
        `IORS_CLOCK_MGMT_FLAGS: w1c_mask = 8'h01;
        `IORS_VOLTAGE_MONITOR_CTL: w1c_mask = 8'h20;
        `IORS_PIN_CHANGE_FLAGS: w1c_mask = 8'h07;
        `IORS_LF_RECEIVER_FLAGS: w1c_mask = 8'h0f;
        `IORS_SENSOR_FLAGS: w1c_mask = 8'h03;
        `IORS_TIMER01_FLAGS: w1c_mask = 8'h03;
        `IORS_TIMER2_FLAGS: w1c_mask = 8'h3f;
        `IORS_TIMER3_FLAGS: w1c_mask = 8'h1f;
        `IORS_EXTERNAL_IRQ_FLAGS: w1c_mask = 8'h03;
        `IORS_SERIAL_PORT_FLAGS: w1c_mask = 8'hc0;
        `IORS_RESET_CAUSE_FLAGS: w1c_mask = 8'h2f;
        // no flags elsewhere
        default: w1c_mask = 8'h00;
      endcase
    end
  endfunction

  // locations whose value comes from live inputs
  // nothing is stored for these; a read sees this cycle's input
  function live_loc;
    input [7:0] a;
    begin
      case (a)
        `IORS_PORT_B_PIN_INPUT: live_loc = 1'b1;
        `IORS_PORT_C_PIN_INPUT: live_loc = 1'b1;
        `IORS_PORT_D_PIN_INPUT: live_loc = 1'b1;
        `IORS_LF_SIGNAL_STRENGTH: live_loc = 1'b1;
        `IORS_LF_RX_BUFFER: live_loc = 1'b1;
        default: live_loc = 1'b0;
      endcase
    end
  endfunction

  // decoded access
  wire low_hit;
  wire [5:0] low_idx;
  wire ext_hit;

  // range checks and i/o-relative index
  iors_addr_map u_map (
    .op_i(op_i),
    .addr_i(addr_i),
    .low_hit_o(low_hit),
    .low_idx_o(low_idx),
    .ext_hit_o(ext_hit)
  );

  // data address of the addressed low location
  // the map returns an index for every form, so one address serves all
  wire [7:0] low_addr = {2'b00, low_idx} + `IORS_IO_OFS;
  // a location that holds anything at all
  // only used to report a write that lands on a hole in the map
  wire low_impl = live_loc(low_addr) ||
                  ((rw_mask(low_addr) | w1c_mask(low_addr)) != 8'h00);

  // op groups
  // skip tests read a location but never write it
  wire is_bset = (op_i == `IORS_OP_BIT_SET);
  wire is_bclr = (op_i == `IORS_OP_BIT_CLR);
  wire is_bitop = is_bset || is_bclr;
  wire is_skip_hi = (op_i == `IORS_OP_SKIP_HI);
  wire is_skip_lo = (op_i == `IORS_OP_SKIP_LO);
  wire is_wr = (op_i == `IORS_OP_PORT_WR) ||
               (op_i == `IORS_OP_WRITE) || is_bitop;
  wire is_rd = (op_i == `IORS_OP_PORT_RD) ||
               (op_i == `IORS_OP_FETCH) || is_skip_hi || is_skip_lo;

  // current value seen by a read of the addressed low location
  // taken before any store of this cycle, so a read never sees its own write
  reg [7:0] low_rd;
  always @* begin
    case (low_addr)
      `IORS_PORT_B_PIN_INPUT: low_rd = port_b_pin_input_i;
      // port c has three pins
      `IORS_PORT_C_PIN_INPUT: low_rd = {5'h00, port_c_pin_input_i[2:0]};
      `IORS_PORT_D_PIN_INPUT: low_rd = port_d_pin_input_i;
      `IORS_LF_SIGNAL_STRENGTH: low_rd = {1'b0, lf_rssi_i};
      `IORS_LF_RX_BUFFER: low_rd = lf_rxbuf_i;
      // stored bits, reserved ones always zero
      default: low_rd = io_mem[low_idx];
    endcase
  end

  // lane and chosen bit for bit operations
  // the skip result uses the same live or stored value as a read
  wire [7:0] lane;
  wire test_bit;
  iors_bit_sel u_bit (
    .byte_i(low_rd),
    .bit_i(bit_i),
    .onehot_o(lane),
    .bit_o(test_bit)
  );

  // write lanes: one lane for bit ops, all lanes otherwise
  wire [7:0] wr_lanes = is_bitop ? lane : 8'hff;
  // bit set writes a one on its lane, bit clear a zero
  // on a flag the set clears it and the clear leaves it, as with a write
  wire [7:0] wr_val = is_bset ? lane : (is_bclr ? 8'h00 : wdata_i);
  // write strobe on the low space
  wire low_wr = is_wr && low_hit;

  // per location update of stored and flag bits
  // each location compares its own index, so at most one takes the write
  genvar gi;
  generate
    for (gi = 0; gi < 64; gi = gi + 1) begin : g_loc
      localparam integer LI = gi + 32;
      localparam [7:0] LA = LI[7:0];
      // writable and flag bits of this location
      wire [7:0] rw = rw_mask(LA);
      wire [7:0] fl = w1c_mask(LA);
      // lanes written this cycle
      wire [7:0] wm = (low_wr && low_idx == gi) ? wr_lanes : 8'h00;
      // hardware events for this location
      wire [7:0] ev = (evt_valid_i && evt_addr_i == LA) ?
                      (evt_bits_i & fl) : 8'h00;
      // plain bits take the value, reserved bits stay zero
      wire [7:0] plain = (io_mem[gi] & ~(wm & rw)) |
                         (wr_val & wm & rw);
      // a written one clears a flag, a zero leaves it
      wire [7:0] cleared = plain & ~(wm & wr_val & fl);
      // an event in the clearing cycle wins
      // or-ing the event last keeps a flag that is raised while cleared
      wire [7:0] next_loc = cleared | ev;
      // register the location
      always @(posedge core_clk_i) begin
        if (!rstn_i) begin
          io_mem[gi] <= `IORS_RESET_VAL;
        end else begin
          io_mem[gi] <= next_loc;
        end
      end
    end
  endgenerate

  // extended space write strobe
  wire ext_wr = is_wr && ext_hit;

  // extended registers, written only by data-space stores
  // the map never raises the extended hit for port or bit forms
  always @(posedge core_clk_i) begin
    if (!rstn_i) begin
      wdt_ctl <= `IORS_RESET_VAL;
      sens_irq_msk <= `IORS_RESET_VAL;
      temp_ctl <= `IORS_RESET_VAL;
    end else if (ext_wr) begin
      // only implemented bits take the data
      case (addr_i)
        `IORS_WATCHDOG_CONTROL: begin
          wdt_ctl <= wdata_i & `IORS_WATCHDOG_MASK;
        end
        `IORS_SENSOR_IRQ_MASK: begin
          sens_irq_msk <= wdata_i & `IORS_SENSOR_IRQ_MASK_BITS;
        end
        `IORS_TEMP_SENSOR_CTL: begin
          temp_ctl <= wdata_i & `IORS_TEMP_SENSOR_BITS;
        end
        // reserved extended addresses ignore the write
        default: begin
          wdt_ctl <= wdt_ctl;
        end
      endcase
    end
  end

  // read value of the extended space
  // every extended value is stored; none comes from a live input
  reg [7:0] ext_rd;
  always @* begin
    case (addr_i)
      `IORS_WATCHDOG_CONTROL: ext_rd = wdt_ctl;
      `IORS_SENSOR_IRQ_MASK: ext_rd = sens_irq_msk;
      `IORS_TEMP_SENSOR_CTL: ext_rd = temp_ctl;
      // reserved extended addresses read zero
      default: ext_rd = 8'h00;
    endcase
  end

  // implemented extended address
  // holes here report a write just as holes in the low space do
  wire ext_impl = (addr_i == `IORS_WATCHDOG_CONTROL) ||
                  (addr_i == `IORS_SENSOR_IRQ_MASK) ||
                  (addr_i == `IORS_TEMP_SENSOR_CTL);

  // response values for the next cycle
  // one op per cycle, so read and write paths never meet
  // a refused read still answers, with zero data
  always @* begin
    next_rd_data = 8'h00;
    next_skip = 1'b0;
    next_err = 1'b0;
    if (is_rd && low_hit) begin
      // port-style or data read, or a skip test
      next_rd_data = low_rd;
      next_skip = (is_skip_hi && test_bit) ||
                  (is_skip_lo && !test_bit);
    end else if (is_rd && ext_hit) begin
      // extended read through data space
      next_rd_data = ext_rd;
    end
    if ((is_rd || is_wr) && !low_hit && !ext_hit) begin
      // out of range for this form of access
      next_err = 1'b1;
    end else if (is_wr && low_hit && !low_impl) begin
      // write to a reserved low location
      next_err = 1'b1;
    end else if (is_wr && ext_hit && !ext_impl) begin
      // write to a reserved extended location
      next_err = 1'b1;
    end
  end

  // response flops toward the cpu datapath
  // each answer stands one cycle, then the next op's answer replaces it, or zero after an idle cycle
  // valid follows every read op, refused or not
  always @(posedge core_clk_i) begin
    if (!rstn_i) begin
      rd_data_o <= 8'h00;
      rd_valid_o <= 1'b0;
      skip_o <= 1'b0;
      err_o <= 1'b0;
    end else begin
      rd_data_o <= next_rd_data;
      rd_valid_o <= is_rd;
      skip_o <= next_skip;
      err_o <= next_err;
    end
  end

  // port and stack pointer registers drive pins directly
  // no extra stage: pins follow the stored bytes
  assign port_b_output_out_o = io_mem[5];
  assign port_b_output_dir_o = io_mem[4];
  assign port_c_output_out_o = io_mem[8];
  assign port_c_output_dir_o = io_mem[7];
  assign port_d_output_out_o = io_mem[11];
  assign port_d_output_dir_o = io_mem[10];
  // ten-bit stack pointer
  // high byte bits 7:2 are never stored, so nothing is lost here
  assign stack_ptr_o = {io_mem[62][1:0], io_mem[61]};

endmodule
`default_nettype wire

// >>> tb/iors_decoder_assertions.sv
// port assertions for the i/o register space decoder
`timescale 1ns/100ps
`default_nettype none
`include "iors_consts.vh"
module iors_decoder_chk (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic [3:0] op_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [2:0] bit_i,
  input wire logic [7:0] rd_data_o,
  input wire logic rd_valid_o,
  input wire logic skip_o,
  input wire logic err_o,
  input wire logic [7:0] port_b_output_out_o,
  input wire logic [9:0] stack_ptr_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  // op classes
  wire skip_op = op_i == `IORS_OP_SKIP_HI || op_i == `IORS_OP_SKIP_LO;
  wire rd_op = op_i == `IORS_OP_PORT_RD || op_i == `IORS_OP_FETCH || skip_op;
  wire port_op = op_i == `IORS_OP_PORT_RD || op_i == `IORS_OP_PORT_WR;
  wire data_op = op_i == `IORS_OP_FETCH || op_i == `IORS_OP_WRITE;
  wire bit_op = op_i >= `IORS_OP_BIT_SET && op_i <= `IORS_OP_SKIP_LO;
  wire at_pb = addr_i == 8'h05;
  // bit of the port b output picked by the bit number, one cycle late
  logic pick_q;
  always @(posedge core_clk_i) begin
    pick_q <= port_b_output_out_o[bit_i];
  end
  AST_READ_ANS: assert property (rd_op |=> rd_valid_o)
    else $error("read op without answer");
  AST_IDLE_QUIET: assert property (op_i == `IORS_OP_IDLE |=>
    !rd_valid_o && !err_o && !skip_o && rd_data_o == 8'h00)
    else $error("outputs active after idle");
  AST_BIT_RANGE: assert property (bit_op && addr_i > `IORS_BIT_LAST
    |=> err_o) else $error("bit op above range accepted");
  AST_PORT_RANGE: assert property (port_op && addr_i > `IORS_IO_LAST
    |=> err_o && rd_data_o == 8'h00) else $error("port op above range");
  AST_DATA_LOW: assert property (data_op && addr_i < `IORS_IO_OFS
    |=> err_o) else $error("data op below offset accepted");
  AST_EXT_DATA: assert property (data_op
    && addr_i == `IORS_WATCHDOG_CONTROL |=> !err_o)
    else $error("extended data access refused");
  AST_PORT_WR: assert property ((op_i == `IORS_OP_PORT_WR && at_pb)
    || (op_i == `IORS_OP_WRITE && addr_i == `IORS_PORT_B_OUTPUT)
    |=> port_b_output_out_o == $past(wdata_i)) else $error("port b write lost");
  AST_BIT_ONLY: assert property (op_i == `IORS_OP_BIT_SET && at_pb
    |=> port_b_output_out_o == ($past(port_b_output_out_o) | (8'h01 << $past(bit_i))))
    else $error("bit set touched other bits");
  AST_SKIP_HI: assert property (op_i == `IORS_OP_SKIP_HI && at_pb
    |=> skip_o == pick_q) else $error("skip high wrong");
  AST_SKIP_LO: assert property (op_i == `IORS_OP_SKIP_LO && at_pb
    |=> skip_o == !pick_q && rd_valid_o) else $error("skip low wrong");
  AST_SP_HIGH: assert property (op_i == `IORS_OP_WRITE
    && addr_i == `IORS_STACK_PTR_HIGH
    |=> {6'h00, stack_ptr_o[9:8]} == ($past(wdata_i) & 8'h03))
    else $error("stack high bits wrong");
  // main scenarios
  cover property (rd_op ##1 rd_valid_o);
  cover property (op_i == `IORS_OP_BIT_SET && at_pb);
  cover property (skip_o);
endmodule
bind iors_decoder iors_decoder_chk u_chk (
  .core_clk_i(core_clk_i),
  .rstn_i(rstn_i),
  .op_i(op_i),
  .addr_i(addr_i),
  .wdata_i(wdata_i),
  .bit_i(bit_i),
  .rd_data_o(rd_data_o),
  .rd_valid_o(rd_valid_o),
  .skip_o(skip_o),
  .err_o(err_o),
  .port_b_output_out_o(port_b_output_out_o),
  .stack_ptr_o(stack_ptr_o)
);
`default_nettype wire

// >>> tb/iors_cpu_model.sv
// cpu datapath model issuing one register op per cycle
`timescale 1ns/100ps
`default_nettype none
`include "iors_consts.vh"
module iors_cpu_model (
  input wire logic clk_i,
  input wire logic [7:0] rd_data_i,
  input wire logic rd_valid_i,
  input wire logic skip_i,
  input wire logic err_i,
  output logic [3:0] op_o,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o,
  output logic [2:0] bit_o
);
  // last answer taken from the decoder
  logic [7:0] got_data;
  logic got_valid, got_skip, got_err;
  initial begin
    op_o = `IORS_OP_IDLE;
    addr_o = 8'h00;
    wdata_o = 8'h00;
    bit_o = 3'h0;
  end
  // issue at a falling edge, take the answer one cycle on; callers keep
  // reserved bits zero except masking probes and never write
  // reserved addresses
  task automatic xfer(input logic [3:0] op, input logic [7:0] a, w,
                      input logic [2:0] b);
    op_o = op;
    addr_o = a;
    wdata_o = w;
    bit_o = b;
    @(negedge clk_i);
    got_data = rd_data_i;
    got_valid = rd_valid_i;
    got_skip = skip_i;
    got_err = err_i;
  endtask
  // release: address and data no longer hold their last values
  task automatic idle();
    op_o = `IORS_OP_IDLE;
    addr_o = ~addr_o;
    wdata_o = ~wdata_o;
    @(negedge clk_i);
  endtask
endmodule
`default_nettype wire

// >>> tb/tb_io_register_space_decoder.sv
// testbench for the i/o register space decoder
`timescale 1ns/100ps
`default_nettype none
`include "iors_consts.vh"
module tb_io_register_space_decoder;
  logic core_clk_i, rstn_i, evt_valid, rd_valid, skip, err;
  logic [3:0] op;
  logic [7:0] addr, wdata, evt_addr, evt_bits, port_b_pin_input, port_c_pin_input, rd_data;
  logic [7:0] pb_out, pb_dir, pc_out, pc_dir, pd_out, pd_dir;
  logic [2:0] bsel;
  logic [9:0] sp;
  int bad_count = 0;
  int n_tests = 0;
  iors_decoder u_dut (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
    .op_i(op), .addr_i(addr), .wdata_i(wdata), .bit_i(bsel),
    .evt_valid_i(evt_valid), .evt_addr_i(evt_addr), .evt_bits_i(evt_bits),
    .port_b_pin_input_i(port_b_pin_input), .port_c_pin_input_i(port_c_pin_input), .port_d_pin_input_i(8'h96), .lf_rssi_i(7'h3c),
    .lf_rxbuf_i(8'h81), .rd_data_o(rd_data), .rd_valid_o(rd_valid),
    .skip_o(skip), .err_o(err), .port_b_output_out_o(pb_out), .port_b_output_dir_o(pb_dir),
    .port_c_output_out_o(pc_out), .port_c_output_dir_o(pc_dir), .port_d_output_out_o(pd_out),
    .port_d_output_dir_o(pd_dir), .stack_ptr_o(sp));
  iors_cpu_model u_cpu (.clk_i(core_clk_i), .rd_data_i(rd_data),
    .rd_valid_i(rd_valid), .skip_i(skip), .err_i(err), .op_o(op),
    .addr_o(addr), .wdata_o(wdata), .bit_o(bsel));
  initial begin
    core_clk_i = 1'b0;
    forever #4 core_clk_i = ~core_clk_i;
  end
  task automatic end_sim();
    $display("tests %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one op whose read data and error flag are judged
  task automatic rd(input logic [3:0] o, input logic [7:0] a, exp,
                    input logic e);
    u_cpu.xfer(o, a, 8'h00, 3'h0);
    chk(u_cpu.got_data, exp);
    chk({7'h00, u_cpu.got_err}, {7'h00, e});
    chk({7'h00, u_cpu.got_valid},
        {7'h00, (o == `IORS_OP_PORT_RD || o == `IORS_OP_FETCH)});
  endtask
  task automatic t_reset();
    chk(pb_out | pc_out | pd_out | pb_dir | pc_dir | pd_dir, 8'h00);
    chk(sp[7:0], 8'h00);
    chk({6'h00, sp[9:8]}, 8'h00);
  endtask
  task automatic t_map();
    u_cpu.xfer(`IORS_OP_PORT_WR, 8'h05, 8'ha5, 3'h0);
    chk(pb_out, 8'ha5);
    rd(`IORS_OP_FETCH, `IORS_PORT_B_OUTPUT, 8'ha5, 1'b0);
    u_cpu.xfer(`IORS_OP_WRITE, `IORS_PORT_D_DIRECTION, 8'h3c, 3'h0);
    rd(`IORS_OP_PORT_RD, 8'h0a, 8'h3c, 1'b0);
    chk(pd_dir, 8'h3c);
    rd(`IORS_OP_PORT_RD, 8'h03, 8'h5a, 1'b0);
    rd(`IORS_OP_PORT_RD, 8'h06, 8'h07, 1'b0);
    rd(`IORS_OP_FETCH, `IORS_LF_SIGNAL_STRENGTH, 8'h3c, 1'b0);
    rd(`IORS_OP_PORT_RD, 8'h0c, 8'h00, 1'b0);
    u_cpu.xfer(`IORS_OP_PORT_WR, 8'h08, 8'hff, 3'h0);
    chk(pc_out, 8'h07);
    u_cpu.xfer(`IORS_OP_WRITE, `IORS_PORT_C_DIRECTION, 8'hfe, 3'h0);
    chk(pc_dir, 8'h06);
    u_cpu.xfer(`IORS_OP_BIT_SET, 8'h0b, 8'h00, 3'h6);
    chk(pd_out, 8'h40);
    rd(`IORS_OP_PORT_RD, 8'h09, 8'h96, 1'b0);
    rd(`IORS_OP_FETCH, `IORS_LF_RX_BUFFER, 8'h81, 1'b0);
    u_cpu.idle();
  endtask
  task automatic t_range();
    rd(`IORS_OP_PORT_RD, 8'h40, 8'h00, 1'b1);
    rd(`IORS_OP_BIT_SET, 8'h20, 8'h00, 1'b1);
    rd(`IORS_OP_FETCH, 8'h10, 8'h00, 1'b1);
    u_cpu.xfer(`IORS_OP_WRITE, `IORS_WATCHDOG_CONTROL, 8'h1f, 3'h0);
    rd(`IORS_OP_FETCH, `IORS_WATCHDOG_CONTROL, 8'h1f, 1'b0);
    rd(`IORS_OP_FETCH, 8'h62, 8'h00, 1'b0);
    u_cpu.idle();
  endtask
  task automatic t_bits();
    u_cpu.xfer(`IORS_OP_PORT_WR, 8'h05, 8'h00, 3'h0);
    u_cpu.xfer(`IORS_OP_BIT_SET, 8'h05, 8'h00, 3'h7);
    u_cpu.xfer(`IORS_OP_BIT_SET, 8'h05, 8'h00, 3'h0);
    u_cpu.xfer(`IORS_OP_BIT_CLR, 8'h05, 8'h00, 3'h7);
    chk(pb_out, 8'h01);
    u_cpu.xfer(`IORS_OP_SKIP_HI, 8'h05, 8'h00, 3'h0);
    chk({7'h00, u_cpu.got_skip}, 8'h01);
    u_cpu.xfer(`IORS_OP_SKIP_LO, 8'h05, 8'h00, 3'h0);
    chk({7'h00, u_cpu.got_skip}, 8'h00);
    u_cpu.xfer(`IORS_OP_SKIP_LO, 8'h05, 8'h00, 3'h3);
    chk({7'h00, u_cpu.got_skip}, 8'h01);
    u_cpu.xfer(`IORS_OP_BIT_SET, 8'h1f, 8'h00, 3'h2);
    rd(`IORS_OP_FETCH, `IORS_EEPROM_CONTROL, 8'h04, 1'b0);
    u_cpu.idle();
  endtask
  task automatic t_flags();
    evt_valid = 1'b1;
    evt_addr = `IORS_TIMER01_FLAGS;
    evt_bits = 8'hff;
    @(negedge core_clk_i);
    evt_valid = 1'b0;
    rd(`IORS_OP_FETCH, `IORS_TIMER01_FLAGS, 8'h03, 1'b0);
    u_cpu.xfer(`IORS_OP_PORT_WR, 8'h1a, 8'h00, 3'h0);
    rd(`IORS_OP_PORT_RD, 8'h1a, 8'h03, 1'b0);
    u_cpu.xfer(`IORS_OP_BIT_SET, 8'h1a, 8'h00, 3'h0);
    rd(`IORS_OP_PORT_RD, 8'h1a, 8'h02, 1'b0);
    u_cpu.xfer(`IORS_OP_BIT_CLR, 8'h1a, 8'h00, 3'h1);
    rd(`IORS_OP_PORT_RD, 8'h1a, 8'h02, 1'b0);
    u_cpu.xfer(`IORS_OP_WRITE, `IORS_TIMER01_FLAGS, 8'h02, 3'h0);
    rd(`IORS_OP_FETCH, `IORS_TIMER01_FLAGS, 8'h00, 1'b0);
    evt_valid = 1'b1;
    evt_bits = 8'h01;
    u_cpu.xfer(`IORS_OP_WRITE, `IORS_TIMER01_FLAGS, 8'h01, 3'h0);
    evt_valid = 1'b0;
    rd(`IORS_OP_FETCH, `IORS_TIMER01_FLAGS, 8'h01, 1'b0);
    u_cpu.idle();
  endtask
  task automatic t_stack();
    u_cpu.xfer(`IORS_OP_WRITE, `IORS_STACK_PTR_HIGH, 8'hff, 3'h0);
    chk({6'h00, sp[9:8]}, 8'h03);
    rd(`IORS_OP_FETCH, `IORS_STACK_PTR_HIGH, 8'h03, 1'b0);
    u_cpu.xfer(`IORS_OP_PORT_WR, 8'h3d, 8'h12, 3'h0);
    chk(sp[7:0], 8'h12);
    u_cpu.idle();
  endtask
  // watchdog at 25000 cycles, well beyond the roughly 53 cycles the tests need
  initial begin
    #200000;
    bad_count++;
    end_sim();
  end
  initial begin
    rstn_i = 1'b0;
    evt_valid = 1'b0;
    evt_addr = 8'h00;
    evt_bits = 8'h00;
    port_b_pin_input = 8'h5a;
    port_c_pin_input = 8'hff;
    repeat (5) @(negedge core_clk_i);
    rstn_i = 1'b1;
    @(negedge core_clk_i);
    t_reset();
    $display("reset test done");
    t_map();
    $display("map test done");
    t_range();
    $display("range test done");
    t_bits();
    $display("bit test done");
    t_flags();
    $display("flag test done");
    t_stack();
    $display("stack test done");
    end_sim();
  end
endmodule
`default_nettype wire
